// file: hw/dss_pkg.sv
package dss_pkg;

  // Status word bit positions
  localparam int unsigned BIT_RTSO    = 0;
  localparam int unsigned BIT_SWON    = 1;
  localparam int unsigned BIT_OPEN    = 2;
  localparam int unsigned BIT_FAULT   = 3;
  localparam int unsigned BIT_VOLT    = 4;
  localparam int unsigned BIT_QSTOP_N = 5;
  localparam int unsigned BIT_SOD     = 6;
  localparam int unsigned BIT_WARN    = 7;
  localparam int unsigned BIT_REMOTE  = 9;
  localparam int unsigned BIT_TARGET  = 10;
  localparam int unsigned BIT_LIMIT   = 11;
  localparam int unsigned BIT_STOPKEY = 14;
  localparam int unsigned BIT_DIR     = 15;
  localparam logic [15:0] STATUS_RESET = 16'h0000;

  // Control word bit positions
  localparam int unsigned CW_SWON   = 0;
  localparam int unsigned CW_VOLT   = 1;
  localparam int unsigned CW_QSTOP  = 2;
  localparam int unsigned CW_ENOP   = 3;
  localparam int unsigned CW_FRESET = 7;
  localparam int unsigned CW_ASSIGN_BASE = 11;
  localparam logic [15:0] CTRL_RESET = 16'h0000;

  // Function source codes: none, then control word bits 11..15
  localparam logic [2:0] SRC_NONE = 3'h0;
  localparam logic [2:0] SRC_B11  = 3'h1;
  localparam logic [2:0] SRC_B12  = 3'h2;
  localparam logic [2:0] SRC_B13  = 3'h3;
  localparam logic [2:0] SRC_B14  = 3'h4;
  localparam logic [2:0] SRC_B15  = 3'h5;
  localparam logic [2:0] REVERSE_ASSIGN_DEFAULT = SRC_B11;

  // Timing: mains timeout counted in milliseconds
  localparam int unsigned CLOCK_HZ   = 20000000;
  localparam int unsigned TICK_US    = 1000;
  localparam int unsigned TICK_CYCLES = CLOCK_HZ / 1000000 * TICK_US;
  localparam int unsigned TIMEOUT_W  = 16;

  typedef enum logic [2:0] {
    ST_NOT_READY,
    ST_SW_ON_DISABLED,
    ST_READY,
    ST_SWITCHED_ON,
    ST_OP_ENABLED,
    ST_QSTOP_ACTIVE,
    ST_FAULT_REACTION,
    ST_FAULT
  } dss_state_t;

endpackage

// file: hw/dss_status.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Control bits 11..15 each selectable by code as a function source.
// - By default control bit 11 drives the reverse direction command.
// - Low byte: ready, on, enabled, fault, voltage, quick stop low, disabled, warn.
// - Masked by 006F: 40, 21, 23, 27, 07, 08 from disabled through fault; 00 in not ready, 0F in fault reaction.
// - Fault following quick stop active reads 28 under the mask.
// - Enable operation from ready goes straight to operation enabled.
// - Separate control stage: ready reads 21 without power, 31 with.
// - Power absent past mains timeout in switched on raises contactor error.
module dss_status #(
  parameter int unsigned TICK_CYCLES = dss_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                           clock,
  input  wire logic                           reset_n,
  // Control word from fieldbus logic
  input  wire logic [15:0]                    ctrl_word,
  input  wire logic                           ctrl_valid,
  // Configuration
  input  wire logic [2:0]                     reverse_direction_assign,
  input  wire logic [2:0]                     dc_braking_source_select,
  input  wire logic [dss_pkg::TIMEOUT_W-1:0]  mains_timeout_ms,
  // Pins from the power stage
  input  wire logic                           power_present_pin,
  input  wire logic                           fault_pin,
  input  wire logic                           stop_key_pin,
  // Drive condition flags, same clock
  input  wire logic                           warning_active,
  input  wire logic                           remote_source,
  input  wire logic                           target_reached,
  input  wire logic                           internal_limit,
  input  wire logic                           direction_reverse,
  // Status
  output logic [15:0]                         drive_status_word,
  output dss_pkg::dss_state_t                 drive_state,
  output logic                                no_power_stage_display,
  output logic                                input_contactor_error,
  // Function outputs
  output logic                                reverse_cmd,
  output logic                                dc_braking_cmd
);

  logic [1:0]          rst_sync_ff;
  logic                rst_n;
  logic [1:0]          pwr_sync_ff;
  logic [1:0]          flt_sync_ff;
  logic [1:0]          key_sync_ff;
  logic                pwr_ok;
  logic [15:0]         ctrl_ff;
  logic                freset_prev_ff;
  logic                freset_rise;
  dss_pkg::dss_state_t state_ff;
  dss_pkg::dss_state_t nxt_state;
  logic                from_qstop_ff;
  logic                contactor_err_ff;
  logic                fault_cause;
  logic [15:0]         nxt_status;
  logic [15:0]         status_ff;
  logic                reverse_ff;
  logic                dc_brake_ff;

  dss_tmr_if tif ();

  // Reset release
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // Pin synchronisers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pwr_sync_ff <= 2'h0;
      flt_sync_ff <= 2'h0;
      key_sync_ff <= 2'h0;
    end else begin
      pwr_sync_ff <= {pwr_sync_ff[0], power_present_pin};
      flt_sync_ff <= {flt_sync_ff[0], fault_pin};
      key_sync_ff <= {key_sync_ff[0], stop_key_pin};
    end
  end
  assign pwr_ok = pwr_sync_ff[1];

  // Control word holding register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= dss_pkg::CTRL_RESET;
    end else if (ctrl_valid) begin
      ctrl_ff <= ctrl_word;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      freset_prev_ff <= 1'b0;
    end else begin
      freset_prev_ff <= ctrl_ff[dss_pkg::CW_FRESET];
    end
  end
  assign freset_rise = ctrl_ff[dss_pkg::CW_FRESET] && !freset_prev_ff;

  // Selects control bit 11..15 by source code; none or unknown code gives 0
  function automatic logic src_bit(input logic [2:0] code, input logic [15:0] cw);
    logic r;
    r = 1'b0;
    if (code >= dss_pkg::SRC_B11 && code <= dss_pkg::SRC_B15) begin
      r = cw[dss_pkg::CW_ASSIGN_BASE + int'(code - dss_pkg::SRC_B11)];
    end
    return r;
  endfunction

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dc_brake_ff <= 1'b0;
    end else begin
      dc_brake_ff <= src_bit(dc_braking_source_select, ctrl_ff);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reverse_ff <= 1'b0;
    end else begin
      reverse_ff <= src_bit(reverse_direction_assign, ctrl_ff);
    end
  end

  assign tif.run      = (state_ff == dss_pkg::ST_SWITCHED_ON) && !pwr_ok;
  assign tif.limit_ms = mains_timeout_ms;

  dss_timeout #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_timeout (
    .clock (clock),
    .rst_n (rst_n),
    .tif   (tif)
  );

  // contactor error latch; a new expiry wins over the reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      contactor_err_ff <= 1'b0;
    end else if (tif.expired) begin
      contactor_err_ff <= 1'b1;
    end else if (freset_rise && state_ff == dss_pkg::ST_FAULT) begin
      contactor_err_ff <= 1'b0;
    end
  end

  // Latched error left out, else the reset that clears it could never leave fault
  assign fault_cause = flt_sync_ff[1] || tif.expired;

  // Operating state transitions
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      dss_pkg::ST_NOT_READY: begin
        nxt_state = dss_pkg::ST_SW_ON_DISABLED;
      end
      dss_pkg::ST_SW_ON_DISABLED: begin
        if (ctrl_ff[2:0] == 3'h6) begin
          nxt_state = dss_pkg::ST_READY;
        end
      end
      dss_pkg::ST_READY: begin
        if (!ctrl_ff[dss_pkg::CW_VOLT] || !ctrl_ff[dss_pkg::CW_QSTOP]) begin
          nxt_state = dss_pkg::ST_SW_ON_DISABLED;
        end else if (ctrl_ff[3:0] == 4'hf) begin
          nxt_state = dss_pkg::ST_OP_ENABLED;
        end else if (ctrl_ff[3:0] == 4'h7) begin
          nxt_state = dss_pkg::ST_SWITCHED_ON;
        end
      end
      dss_pkg::ST_SWITCHED_ON: begin
        if (!ctrl_ff[dss_pkg::CW_VOLT] || !ctrl_ff[dss_pkg::CW_QSTOP]) begin
          nxt_state = dss_pkg::ST_SW_ON_DISABLED;
        end else if (!ctrl_ff[dss_pkg::CW_SWON]) begin
          nxt_state = dss_pkg::ST_READY;
        end else if (ctrl_ff[dss_pkg::CW_ENOP]) begin
          nxt_state = dss_pkg::ST_OP_ENABLED;
        end
      end
      dss_pkg::ST_OP_ENABLED: begin
        if (!ctrl_ff[dss_pkg::CW_VOLT]) begin
          nxt_state = dss_pkg::ST_SW_ON_DISABLED;
        end else if (!ctrl_ff[dss_pkg::CW_QSTOP]) begin
          nxt_state = dss_pkg::ST_QSTOP_ACTIVE;
        end else if (!ctrl_ff[dss_pkg::CW_SWON]) begin
          nxt_state = dss_pkg::ST_READY;
        end else if (!ctrl_ff[dss_pkg::CW_ENOP]) begin
          nxt_state = dss_pkg::ST_SWITCHED_ON;
        end
      end
      dss_pkg::ST_QSTOP_ACTIVE: begin
        if (!ctrl_ff[dss_pkg::CW_VOLT]) begin
          nxt_state = dss_pkg::ST_SW_ON_DISABLED;
        end
      end
      dss_pkg::ST_FAULT_REACTION: begin
        nxt_state = dss_pkg::ST_FAULT;
      end
      dss_pkg::ST_FAULT: begin
        if (freset_rise && !fault_cause) begin
          nxt_state = dss_pkg::ST_SW_ON_DISABLED;
        end
      end
      default: begin
        nxt_state = dss_pkg::ST_NOT_READY;
      end
    endcase
    if (fault_cause && state_ff != dss_pkg::ST_FAULT_REACTION
        && state_ff != dss_pkg::ST_FAULT) begin
      nxt_state = dss_pkg::ST_FAULT_REACTION;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= dss_pkg::ST_NOT_READY;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // remember fault entered from quick stop
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      from_qstop_ff <= 1'b0;
    end else if (nxt_state == dss_pkg::ST_FAULT_REACTION) begin
      from_qstop_ff <= (state_ff == dss_pkg::ST_QSTOP_ACTIVE);
    end else if (nxt_state == dss_pkg::ST_SW_ON_DISABLED) begin
      from_qstop_ff <= 1'b0;
    end
  end

  // Status word assembly
  always_comb begin
    nxt_status = 16'h0000;
    case (state_ff)
      dss_pkg::ST_SW_ON_DISABLED: nxt_status[dss_pkg::BIT_SOD] = 1'b1;
      dss_pkg::ST_READY:          nxt_status[dss_pkg::BIT_QSTOP_N] = 1'b1;
      dss_pkg::ST_SWITCHED_ON:    nxt_status[dss_pkg::BIT_QSTOP_N] = 1'b1;
      dss_pkg::ST_OP_ENABLED:     nxt_status[dss_pkg::BIT_QSTOP_N] = 1'b1;
      dss_pkg::ST_FAULT:          nxt_status[dss_pkg::BIT_QSTOP_N] = from_qstop_ff;
      default:                    nxt_status[dss_pkg::BIT_QSTOP_N] = 1'b0;
    endcase
    nxt_status[dss_pkg::BIT_RTSO]  = state_ff inside {dss_pkg::ST_READY,
        dss_pkg::ST_SWITCHED_ON, dss_pkg::ST_OP_ENABLED, dss_pkg::ST_QSTOP_ACTIVE,
        dss_pkg::ST_FAULT_REACTION};
    nxt_status[dss_pkg::BIT_SWON]  = state_ff inside {dss_pkg::ST_SWITCHED_ON,
        dss_pkg::ST_OP_ENABLED, dss_pkg::ST_QSTOP_ACTIVE, dss_pkg::ST_FAULT_REACTION};
    nxt_status[dss_pkg::BIT_OPEN]  = state_ff inside {dss_pkg::ST_OP_ENABLED,
        dss_pkg::ST_QSTOP_ACTIVE, dss_pkg::ST_FAULT_REACTION};
    nxt_status[dss_pkg::BIT_FAULT] = state_ff inside {dss_pkg::ST_FAULT_REACTION,
        dss_pkg::ST_FAULT};
    nxt_status[dss_pkg::BIT_VOLT]    = pwr_ok;
    nxt_status[dss_pkg::BIT_WARN]    = warning_active;
    // high byte, reserved bits stay zero
    nxt_status[dss_pkg::BIT_REMOTE]  = remote_source;
    nxt_status[dss_pkg::BIT_TARGET]  = target_reached;
    nxt_status[dss_pkg::BIT_LIMIT]   = internal_limit;
    nxt_status[dss_pkg::BIT_STOPKEY] = key_sync_ff[1];
    nxt_status[dss_pkg::BIT_DIR]     = direction_reverse;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      status_ff <= dss_pkg::STATUS_RESET;
    end else begin
      status_ff <= nxt_status;
    end
  end

  assign drive_status_word      = status_ff;
  assign drive_state            = state_ff;
  assign no_power_stage_display = !status_ff[dss_pkg::BIT_VOLT];
  assign input_contactor_error  = contactor_err_ff;
  assign reverse_cmd            = reverse_ff;
  assign dc_braking_cmd         = dc_brake_ff;

endmodule // dss_status

// file: hw/dss_timeout.sv
`timescale 1ns/1ps
module dss_timeout #(
  parameter int unsigned TICK_CYCLES = dss_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic   clock,
  input  wire logic   rst_n,
  // Timer control
  dss_tmr_if.tmr      tif
);

  localparam int unsigned DW = $clog2(TICK_CYCLES + 1);
  localparam logic [DW-1:0] DIV_LAST = DW'(TICK_CYCLES - 1);

  logic [DW-1:0]                 div_ff;
  logic [dss_pkg::TIMEOUT_W-1:0] ms_ff;
  logic                          tick;

  assign tick = (div_ff == DIV_LAST);

  // Millisecond enable; restarts with each run so the first ms is whole
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      div_ff <= '0;
    end else if (!tif.run || tick) begin
      div_ff <= '0;
    end else begin
      div_ff <= div_ff + DW'(1);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ms_ff <= '0;
    end else if (!tif.run) begin
      ms_ff <= '0;
    end else if (tick && !tif.expired) begin
      ms_ff <= ms_ff + dss_pkg::TIMEOUT_W'(1);
    end
  end

  assign tif.expired = tif.run && (ms_ff >= tif.limit_ms);

endmodule // dss_timeout

// file: hw/dss_tmr_if.sv
`timescale 1ns/1ps
interface dss_tmr_if;
  logic                           run;
  logic [dss_pkg::TIMEOUT_W-1:0]  limit_ms;
  logic                           expired;

  modport ctrl (output run, output limit_ms, input expired);
  modport tmr  (input run, input limit_ms, output expired);
endinterface

// file: tb/dss_plc_model.sv
`timescale 1ns/1ps
module dss_plc_model (
  // Clock
  input  wire logic        clock,
  // Bench requests
  input  wire logic        start,
  input  wire logic        separate,
  input  wire logic        send,
  input  wire logic [15:0] word,
  // Device side
  input  wire logic [15:0] status,
  output logic      [15:0] ctrl_word,
  output logic             ctrl_valid,
  output logic             done
);
  logic [1:0] step_ff = 2'h0;
  logic       ok;

  initial begin
    ctrl_word  = 16'h0000;
    ctrl_valid = 1'b0;
    done       = 1'b0;
  end

  // separate stage also waits for voltage present
  assign ok = (status & 16'h006f) == 16'h0021 && (!separate || status[4]);

  // reference value is outside this model
  always @(posedge clock) begin
    ctrl_valid <= 1'b0;
    case (step_ff)
      2'h0: if (start) begin
        ctrl_word  <= 16'h0006;
        ctrl_valid <= 1'b1;
        done       <= 1'b0;
        step_ff    <= 2'h1;
      end else if (send) begin
        ctrl_word  <= word;
        ctrl_valid <= 1'b1;
      end
      2'h1: if (ok) begin
        ctrl_word  <= separate ? 16'h0007 : 16'h000f;
        ctrl_valid <= 1'b1;
        step_ff    <= separate ? 2'h2 : 2'h3;
      end
      2'h2: if ((status & 16'h006f) == 16'h0023) begin
        ctrl_word  <= 16'h000f;
        ctrl_valid <= 1'b1;
        step_ff    <= 2'h3;
      end
      default: if ((status & 16'h006f) == 16'h0027) begin
        done    <= 1'b1;
        step_ff <= 2'h0;
      end
    endcase
  end
endmodule // dss_plc_model

// file: tb/dss_status_checker.sv
`timescale 1ns/1ps
module dss_status_checker #(
  parameter int unsigned TICK_CYCLES = 4
) (
  // Clock, reset, control
  input wire logic                          clock,
  input wire logic                          reset_n,
  input wire logic [15:0]                   ctrl_word,
  input wire logic                          ctrl_valid,
  input wire logic [2:0]                    reverse_direction_assign,
  input wire logic [2:0]                    dc_braking_source_select,
  input wire logic [dss_pkg::TIMEOUT_W-1:0] mains_timeout_ms,
  // Pins and flags
  input wire logic                          power_present_pin,
  input wire logic                          fault_pin,
  input wire logic                          stop_key_pin,
  input wire logic                          warning_active,
  input wire logic                          remote_source,
  input wire logic                          target_reached,
  input wire logic                          internal_limit,
  input wire logic                          direction_reverse,
  // Outputs
  input wire logic [15:0]                   drive_status_word,
  input wire dss_pkg::dss_state_t           drive_state,
  input wire logic                          no_power_stage_display,
  input wire logic                          input_contactor_error,
  input wire logic                          reverse_cmd,
  input wire logic                          dc_braking_cmd
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  logic [15:0] m;
  assign m = drive_status_word & 16'h006f;

  function automatic logic pick(logic [15:0] w, logic [2:0] c);
    return (c >= 3'h1 && c <= 3'h5) ? w[10 + c] : 1'b0;
  endfunction

  AST_SOD: assert property (drive_state == dss_pkg::ST_SW_ON_DISABLED |=> m == 16'h0040)
    else $error("code wrong in disabled");
  AST_RDY: assert property (drive_state == dss_pkg::ST_READY |=> m == 16'h0021)
    else $error("code wrong in ready");
  AST_SWON: assert property (drive_state == dss_pkg::ST_SWITCHED_ON |=> m == 16'h0023)
    else $error("code wrong in switched on");
  AST_OPEN: assert property (drive_state == dss_pkg::ST_OP_ENABLED |=> m == 16'h0027)
    else $error("code wrong in enabled");
  AST_QSTOP: assert property (drive_state == dss_pkg::ST_QSTOP_ACTIVE |=> m == 16'h0007)
    else $error("code wrong in quick stop");
  AST_FAULT: assert property (drive_state == dss_pkg::ST_FAULT |=> (m & 16'h004f) == 16'h0008)
    else $error("code wrong in fault");
  AST_REACT: assert property (drive_state == dss_pkg::ST_FAULT_REACTION
    |=> drive_status_word[6:0] ==? 7'b0xx1111)
    else $error("code wrong in fault reaction");
  AST_RSVD: assert property ((drive_status_word & 16'h3100) == 16'h0000)
    else $error("reserved status bit set");
  AST_DISPLAY: assert property (no_power_stage_display == !drive_status_word[4])
    else $error("no power display wrong");
  AST_COPY: assert property (drive_state != dss_pkg::ST_NOT_READY |=>
    {drive_status_word[15], drive_status_word[11:9], drive_status_word[7]} == $past(
    {direction_reverse, internal_limit, target_reached, remote_source, warning_active}))
    else $error("flag bits not copied");
  AST_REV: assert property (ctrl_valid ##1 $stable(reverse_direction_assign) |=>
    reverse_cmd == pick($past(ctrl_word, 2), $past(reverse_direction_assign)))
    else $error("reverse command wrong");
  AST_DCB: assert property (ctrl_valid ##1 $stable(dc_braking_source_select) |=>
    dc_braking_cmd == pick($past(ctrl_word, 2), $past(dc_braking_source_select)))
    else $error("braking command wrong");
  AST_CONT: assert property ($rose(input_contactor_error) |->
    $past(drive_state) == dss_pkg::ST_SWITCHED_ON)
    else $error("contactor error outside switched on");
  AST_FLT: assert property (drive_state == dss_pkg::ST_OP_ENABLED && $rose(fault_pin)
    |-> ##[1:5] drive_state == dss_pkg::ST_FAULT_REACTION)
    else $error("fault not reacted");
endmodule // dss_status_checker

bind dss_status dss_status_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.*);

// file: tb/test_drive_state_status_word.sv
`timescale 1ns/1ps
module test_drive_state_status_word;
  localparam int unsigned TICKS = 4;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic [2:0] rev_sel = 3'h1;
  logic [2:0] dcb_sel = 3'h0;
  logic [15:0] tmo = 16'h0003;
  logic pwr = 1'b1;
  logic flt = 1'b0;
  logic stopk = 1'b0;
  logic [4:0] flags = 5'h00;
  logic start = 1'b0;
  logic sep = 1'b0;
  logic send = 1'b0;
  logic [15:0] word = 16'h0000;
  logic [15:0] ctrl_word;
  logic ctrl_valid;
  logic done;
  logic [15:0] status;
  dss_pkg::dss_state_t state;
  logic npd;
  logic cerr;
  logic rcmd;
  logic dcmd;
  int bad_count = 0;
  int num_checks = 0;
  int cycles = 0;

  initial begin
    forever #25 clock = ~clock;
  end

  dss_status #(.TICK_CYCLES(TICKS)) u_dut (.clock(clock), .reset_n(reset_n),
    .ctrl_word(ctrl_word), .ctrl_valid(ctrl_valid), .reverse_direction_assign(rev_sel),
    .dc_braking_source_select(dcb_sel), .mains_timeout_ms(tmo), .power_present_pin(pwr),
    .fault_pin(flt), .stop_key_pin(stopk), .warning_active(flags[0]),
    .remote_source(flags[1]), .target_reached(flags[2]), .internal_limit(flags[3]),
    .direction_reverse(flags[4]), .drive_status_word(status), .drive_state(state),
    .no_power_stage_display(npd), .input_contactor_error(cerr), .reverse_cmd(rcmd),
    .dc_braking_cmd(dcmd));

  dss_plc_model u_plc (.clock(clock), .start(start), .separate(sep), .send(send),
    .word(word), .status(status), .ctrl_word(ctrl_word), .ctrl_valid(ctrl_valid),
    .done(done));

  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      stop_test();
    end
  end

  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cmd(logic [15:0] w);
    @(posedge clock);
    word <= w;
    send <= 1'b1;
    @(posedge clock);
    send <= 1'b0;
    repeat (4) @(posedge clock);
  endtask

  task automatic wait_mask(logic [15:0] exp);
    for (int i = 0; i < 60 && (status & 16'h006f) !== exp; i++) @(posedge clock);
    chk("masked status", status & 16'h006f, exp);
  endtask

  task automatic go_enabled(logic s);
    @(posedge clock);
    sep <= s;
    start <= 1'b1;
    @(posedge clock);
    start <= 1'b0;
    // Let the model drop the done flag left from the previous run
    @(posedge clock);
    for (int i = 0; i < 80 && done !== 1'b1; i++) @(posedge clock);
    chk("sequence done", 16'(done), 16'h0001);
  endtask

  task automatic clear_fault;
    flt <= 1'b0;
    pwr <= 1'b1;
    cmd(16'h0000);
    cmd(16'h0080);
    wait_mask(16'h0040);
  endtask

  task automatic t_reset;
    repeat (20) @(posedge clock);
    chk("status in reset", status, dss_pkg::STATUS_RESET);
    chk("display in reset", 16'(npd), 16'h0001);
    reset_n <= 1'b1;
    wait_mask(16'h0040);
    $display("reset test done");
  endtask

  task automatic t_assign;
    for (int c = 0; c < 8; c++) begin
      rev_sel <= 3'(c);
      dcb_sel <= 3'(c);
      for (int b = 0; b < 5; b++) begin
        cmd(16'h0800 << b);
        chk("braking cmd", 16'(dcmd), 16'(c == b + 1));
        chk("reverse cmd", 16'(rcmd), 16'(c == b + 1));
      end
    end
    rev_sel <= dss_pkg::REVERSE_ASSIGN_DEFAULT;
    $display("assign test done");
  endtask

  task automatic t_flags;
    flags <= 5'h1f;
    stopk <= 1'b1;
    repeat (6) @(posedge clock);
    chk("high byte", status & 16'hff80, 16'hce80);
    flags <= 5'h00;
    stopk <= 1'b0;
    $display("flag test done");
  endtask

  task automatic t_shared;
    go_enabled(1'b0);
    chk("enabled code", status & 16'h007f, 16'h0037);
    flt <= 1'b1;
    wait_mask(16'h0008);
    clear_fault();
    go_enabled(1'b0);
    cmd(16'h0002);
    wait_mask(16'h0007);
    flt <= 1'b1;
    wait_mask(16'h0028);
    clear_fault();
    $display("shared supply test done");
  endtask

  task automatic t_separate;
    pwr <= 1'b0;
    @(posedge clock);
    sep <= 1'b1;
    start <= 1'b1;
    @(posedge clock);
    start <= 1'b0;
    repeat (10) @(posedge clock);
    chk("ready no power", status, 16'h0021);
    pwr <= 1'b1;
    repeat (6) @(posedge clock);
    chk("ready with power", status, 16'h0031);
    for (int i = 0; i < 80 && done !== 1'b1; i++) @(posedge clock);
    chk("enabled word", status, 16'h0037);
    cmd(16'h0007);
    wait_mask(16'h0023);
    cmd(16'h0006);
    wait_mask(16'h0021);
    cmd(16'h0000);
    wait_mask(16'h0040);
    $display("separate stage test done");
  endtask

  task automatic t_timeout;
    pwr <= 1'b0;
    cmd(16'h0006);
    cmd(16'h0007);
    wait_mask(16'h0023);
    chk("contactor early", 16'(cerr), 16'h0000);
    wait_mask(16'h0008);
    chk("contactor error", 16'(cerr), 16'h0001);
    clear_fault();
    chk("contactor cleared", 16'(cerr), 16'h0000);
    $display("timeout test done");
  endtask

  initial begin
    t_reset();
    t_assign();
    t_flags();
    t_shared();
    t_separate();
    t_timeout();
    stop_test();
  end
endmodule // test_drive_state_status_word
